/* File: ipc_pkg.sv */
// Purpose: constants for the interrupt priority and test/status block
// Assumes: 16-bit registers on a plain strobe port, one clock
// Notes: register offsets are word indices on the register port
package ipc_pkg;
  localparam int unsigned NUM_SRC = 16;
  localparam int unsigned ADDR_W = 4;
  localparam logic [3:0] OFF_CHARGE = 4'h0;
  localparam logic [3:0] OFF_UART3 = 4'h1;
  localparam logic [3:0] OFF_U4E_USB_I2C3 = 4'h2;
  localparam logic [3:0] OFF_SPI3_UART4 = 4'h3;
  localparam logic [3:0] OFF_CAPCMP9 = 4'h4;
  localparam logic [3:0] OFF_GRAPHICS = 4'h5;
  localparam logic [3:0] OFF_TEST_STATUS = 4'h6;
  localparam logic [3:0] OFF_CONTROL_ONE = 4'h7;
  localparam logic [3:0] OFF_PENDING = 4'h8;
  localparam logic [3:0] OFF_ENABLE = 4'h9;
  localparam logic [3:0] OFF_CPU_LEVEL = 4'hA;
  localparam logic [2:0] LEVEL_RESET = 3'h4;
  localparam logic [2:0] LEVEL_OFF = 3'h0;
  localparam logic [3:0] USER_MAX = 4'h7;
  localparam int unsigned BIT_UNACKED = 15;
  localparam int unsigned BIT_VSEL = 13;
  localparam int unsigned BIT_NEST_DIS = 15;
  localparam logic [6:0] VEC_BASE = 7'h08;
  // source index per priority field, in vector order
  localparam int unsigned S_CHARGE = 0;
  localparam int unsigned S_U3ERR = 1;
  localparam int unsigned S_U3RX = 2;
  localparam int unsigned S_U3TX = 3;
  localparam int unsigned S_I2C3S = 4;
  localparam int unsigned S_I2C3M = 5;
  localparam int unsigned S_OTG = 6;
  localparam int unsigned S_U4ERR = 7;
  localparam int unsigned S_U4RX = 8;
  localparam int unsigned S_U4TX = 9;
  localparam int unsigned S_SPI3F = 10;
  localparam int unsigned S_SPI3E = 11;
  localparam int unsigned S_CMP9 = 12;
  localparam int unsigned S_CAP9 = 13;
  localparam int unsigned S_GFX = 14;
  localparam int unsigned S_SPARE = 15;
  // field positions (low bit of each 3-bit field)
  localparam int unsigned POS_HI = 12;
  localparam int unsigned POS_MH = 8;
  localparam int unsigned POS_ML = 4;
  localparam int unsigned POS_LO = 0;
endpackage : ipc_pkg

/* File: ipc_ctrl.sv */
// Purpose: priority fields, pending/enable flags, arbitration and test/status register
// Assumes: cpu_level_i/ack_i come from the cpu core on ref_clk; src_event_i on ref_clk
// Notes: one-cycle read latency, no wait states; unmapped reads give zero
//
// Behaviour
// - each priority field is three bits, 7 highest, 1 lowest
// - a field of zero disables the source entirely
// - all priority fields reset to level 4
// - unimplemented bits ignore writes and read zero
// - uart3 tx at 14-12, rx at 10-8, error at 6-4
// - uart4 err 14-12, otg 10-8, i2c3 master 6-4, slave 2-0
// - spi3 event 14-12, fault 10-8, uart4 tx 6-4, rx 2-0
// - charge unit level at 6-4, rest unimplemented
// - capture9 at 6-4, compare9 at 2-0, upper bits unimplemented
// - graphics level at 2-0, rest unimplemented
// - bit 15 flags a request held off by cpu priority or by the nesting gate
// - bit 13 selects pending or last acknowledged vector
// - bits 11-8 show the new cpu level, 0 to 15
// - bits 6-0 show a vector number 0 to 118
// - user request goes to cpu only above current cpu level
// - nesting disable blocks user requests while one is in service
// - only enabled sources raise a request
// - trap levels 8-15 are not masked by cpu level
// - pending flag stays set until software clears it
`timescale 1ns/1ps
`default_nettype none
module ipc_ctrl (
  input wire logic ref_clk,
  input wire logic rst_n,
  input wire logic [3:0] reg_addr,
  input wire logic [15:0] reg_wdata,
  input wire logic reg_wr,
  input wire logic reg_rd,
  output logic [15:0] reg_rdata,
  input wire logic [15:0] src_event_i,
  input wire logic [3:0] cpu_level_i,
  input wire logic trap_req_i,
  input wire logic [3:0] trap_level_i,
  input wire logic cpu_ack_i,
  input wire logic cpu_return_i,
  output logic irq_o,
  output logic [3:0] irq_level_o,
  output logic [6:0] irq_vector_o
);
  logic [2:0] lvl_ff [ipc_pkg::NUM_SRC];
  logic [15:0] pend_ff;
  logic [15:0] en_ff;
  logic vsel_ff;
  logic nest_dis_ff;
  logic in_service_ff;
  logic [6:0] last_vec_ff;
  logic [3:0] new_level_ff;
  logic unacked_ff;
  logic [15:0] rdata_ff;
  logic [3:0] best_lvl;
  logic [3:0] best_idx;
  logic best_valid;
  logic forward;
  logic [3:0] fwd_level;
  logic [6:0] fwd_vector;
  logic [15:0] nxt_rdata;

  function automatic logic [15:0] fld(input logic [2:0] v, input int unsigned pos);
    fld = 16'(v) << pos;
  endfunction

  function automatic logic [2:0] pick(input logic [15:0] d, input int unsigned pos);
    pick = d[pos +: 3];
  endfunction

  function automatic logic [6:0] vec_of(input logic [3:0] idx);
    vec_of = ipc_pkg::VEC_BASE + 7'(idx);
  endfunction

  function automatic logic hit(input logic wr, input logic [3:0] addr, input logic [3:0] off);
    hit = wr && addr == off;
  endfunction

  // priority fields; unmapped bit positions are simply never stored
  always_ff @(posedge ref_clk) begin
    if (!rst_n) begin
      for (int i = 0; i < ipc_pkg::NUM_SRC; i++) begin
        lvl_ff[i] <= ipc_pkg::LEVEL_RESET;
      end
    end else if (reg_wr) begin
      case (reg_addr)
        ipc_pkg::OFF_CHARGE: begin
          lvl_ff[ipc_pkg::S_CHARGE] <= pick(reg_wdata, ipc_pkg::POS_ML);
        end
        ipc_pkg::OFF_UART3: begin
          lvl_ff[ipc_pkg::S_U3TX] <= pick(reg_wdata, ipc_pkg::POS_HI);
          lvl_ff[ipc_pkg::S_U3RX] <= pick(reg_wdata, ipc_pkg::POS_MH);
          lvl_ff[ipc_pkg::S_U3ERR] <= pick(reg_wdata, ipc_pkg::POS_ML);
        end
        ipc_pkg::OFF_U4E_USB_I2C3: begin
          lvl_ff[ipc_pkg::S_U4ERR] <= pick(reg_wdata, ipc_pkg::POS_HI);
          lvl_ff[ipc_pkg::S_OTG] <= pick(reg_wdata, ipc_pkg::POS_MH);
          lvl_ff[ipc_pkg::S_I2C3M] <= pick(reg_wdata, ipc_pkg::POS_ML);
          lvl_ff[ipc_pkg::S_I2C3S] <= pick(reg_wdata, ipc_pkg::POS_LO);
        end
        ipc_pkg::OFF_SPI3_UART4: begin
          lvl_ff[ipc_pkg::S_SPI3E] <= pick(reg_wdata, ipc_pkg::POS_HI);
          lvl_ff[ipc_pkg::S_SPI3F] <= pick(reg_wdata, ipc_pkg::POS_MH);
          lvl_ff[ipc_pkg::S_U4TX] <= pick(reg_wdata, ipc_pkg::POS_ML);
          lvl_ff[ipc_pkg::S_U4RX] <= pick(reg_wdata, ipc_pkg::POS_LO);
        end
        ipc_pkg::OFF_CAPCMP9: begin
          lvl_ff[ipc_pkg::S_CAP9] <= pick(reg_wdata, ipc_pkg::POS_ML);
          lvl_ff[ipc_pkg::S_CMP9] <= pick(reg_wdata, ipc_pkg::POS_LO);
        end
        ipc_pkg::OFF_GRAPHICS: begin
          lvl_ff[ipc_pkg::S_GFX] <= pick(reg_wdata, ipc_pkg::POS_LO);
        end
        default: begin
        end
      endcase
    end
  end

  // pending flags: hardware set wins over a software clear in the same cycle
  always_ff @(posedge ref_clk) begin
    if (!rst_n) begin
      pend_ff <= 16'h0000;
    end else if (hit(reg_wr, reg_addr, ipc_pkg::OFF_PENDING)) begin
      pend_ff <= reg_wdata | src_event_i;
    end else begin
      pend_ff <= pend_ff | src_event_i;
    end
  end

  always_ff @(posedge ref_clk) begin
    if (!rst_n) begin
      en_ff <= 16'h0000;
    end else if (hit(reg_wr, reg_addr, ipc_pkg::OFF_ENABLE)) begin
      en_ff <= reg_wdata;
    end
  end

  always_ff @(posedge ref_clk) begin
    if (!rst_n) begin
      vsel_ff <= 1'b0;
    end else if (hit(reg_wr, reg_addr, ipc_pkg::OFF_TEST_STATUS)) begin
      vsel_ff <= reg_wdata[ipc_pkg::BIT_VSEL];
    end
  end

  always_ff @(posedge ref_clk) begin
    if (!rst_n) begin
      nest_dis_ff <= 1'b0;
    end else if (hit(reg_wr, reg_addr, ipc_pkg::OFF_CONTROL_ONE)) begin
      nest_dis_ff <= reg_wdata[ipc_pkg::BIT_NEST_DIS];
    end
  end

  // strict compare keeps the lowest index on ties
  always_comb begin
    best_lvl = 4'h0;
    best_idx = 4'h0;
    best_valid = 1'b0;
    for (int i = 0; i < ipc_pkg::NUM_SRC; i++) begin
      if (pend_ff[i] && en_ff[i] && lvl_ff[i] != ipc_pkg::LEVEL_OFF) begin
        if (!best_valid || {1'b0, lvl_ff[i]} > best_lvl) begin
          best_lvl = {1'b0, lvl_ff[i]};
          best_idx = 4'(i);
          best_valid = 1'b1;
        end
      end
    end
  end

  // traps bypass the cpu level and nesting gate; user requests do not
  always_comb begin
    forward = 1'b0;
    fwd_level = best_lvl;
    fwd_vector = vec_of(best_idx);
    if (trap_req_i && trap_level_i > ipc_pkg::USER_MAX) begin
      forward = 1'b1;
      fwd_level = trap_level_i;
      fwd_vector = 7'h00;
    end else if (best_valid && best_lvl > cpu_level_i && !(nest_dis_ff && in_service_ff)) begin
      forward = 1'b1;
    end
  end

  assign irq_o = forward;
  assign irq_level_o = fwd_level;
  assign irq_vector_o = fwd_vector;

  always_ff @(posedge ref_clk) begin
    if (!rst_n) begin
      in_service_ff <= 1'b0;
    end else if (forward && cpu_ack_i) begin
      in_service_ff <= 1'b1;
    end else if (cpu_return_i) begin
      in_service_ff <= 1'b0;
    end
  end

  always_ff @(posedge ref_clk) begin
    if (!rst_n) begin
      last_vec_ff <= 7'h00;
      new_level_ff <= 4'h0;
    end else if (forward && cpu_ack_i) begin
      last_vec_ff <= fwd_vector;
      new_level_ff <= fwd_level;
    end
  end

  // request present but held off by the cpu level or the nesting gate
  always_ff @(posedge ref_clk) begin
    if (!rst_n) begin
      unacked_ff <= 1'b0;
    end else begin
      unacked_ff <= best_valid && !forward;
    end
  end

  always_comb begin
    nxt_rdata = 16'h0000;
    case (reg_addr)
      ipc_pkg::OFF_CHARGE: begin
        nxt_rdata = fld(lvl_ff[ipc_pkg::S_CHARGE], ipc_pkg::POS_ML);
      end
      ipc_pkg::OFF_UART3: begin
        nxt_rdata = fld(lvl_ff[ipc_pkg::S_U3TX], ipc_pkg::POS_HI) | fld(lvl_ff[ipc_pkg::S_U3RX], ipc_pkg::POS_MH)
          | fld(lvl_ff[ipc_pkg::S_U3ERR], ipc_pkg::POS_ML);
      end
      ipc_pkg::OFF_U4E_USB_I2C3: begin
        nxt_rdata = fld(lvl_ff[ipc_pkg::S_U4ERR], ipc_pkg::POS_HI) | fld(lvl_ff[ipc_pkg::S_OTG], ipc_pkg::POS_MH)
          | fld(lvl_ff[ipc_pkg::S_I2C3M], ipc_pkg::POS_ML) | fld(lvl_ff[ipc_pkg::S_I2C3S], ipc_pkg::POS_LO);
      end
      ipc_pkg::OFF_SPI3_UART4: begin
        nxt_rdata = fld(lvl_ff[ipc_pkg::S_SPI3E], ipc_pkg::POS_HI) | fld(lvl_ff[ipc_pkg::S_SPI3F], ipc_pkg::POS_MH)
          | fld(lvl_ff[ipc_pkg::S_U4TX], ipc_pkg::POS_ML) | fld(lvl_ff[ipc_pkg::S_U4RX], ipc_pkg::POS_LO);
      end
      ipc_pkg::OFF_CAPCMP9: begin
        nxt_rdata = fld(lvl_ff[ipc_pkg::S_CAP9], ipc_pkg::POS_ML) | fld(lvl_ff[ipc_pkg::S_CMP9], ipc_pkg::POS_LO);
      end
      ipc_pkg::OFF_GRAPHICS: begin
        nxt_rdata = fld(lvl_ff[ipc_pkg::S_GFX], ipc_pkg::POS_LO);
      end
      ipc_pkg::OFF_TEST_STATUS: begin
        nxt_rdata[ipc_pkg::BIT_UNACKED] = unacked_ff;
        nxt_rdata[ipc_pkg::BIT_VSEL] = vsel_ff;
        nxt_rdata[11:8] = new_level_ff;
        nxt_rdata[6:0] = (vsel_ff && best_valid) ? vec_of(best_idx) : last_vec_ff;
      end
      ipc_pkg::OFF_CONTROL_ONE: begin
        nxt_rdata[ipc_pkg::BIT_NEST_DIS] = nest_dis_ff;
      end
      ipc_pkg::OFF_PENDING: begin
        nxt_rdata = pend_ff;
      end
      ipc_pkg::OFF_ENABLE: begin
        nxt_rdata = en_ff;
      end
      ipc_pkg::OFF_CPU_LEVEL: begin
        nxt_rdata[3:0] = cpu_level_i;
      end
      default: begin
        nxt_rdata = 16'h0000;
      end
    endcase
  end

  // data is held only in the cycle after the read strobe
  always_ff @(posedge ref_clk) begin
    if (!rst_n) begin
      rdata_ff <= 16'h0000;
    end else if (reg_rd) begin
      rdata_ff <= nxt_rdata;
    end else begin
      rdata_ff <= 16'h0000;
    end
  end

  assign reg_rdata = rdata_ff;
endmodule : ipc_ctrl
`default_nettype wire

/* File: ipc_ctrl_monitor.sv */
// Purpose: port checker for ipc_ctrl
// Assumes: one clock, sync active-low reset
// Notes: bound to every ipc_ctrl instance
`timescale 1ns/1ps
`default_nettype none
module ipc_ctrl_monitor (
  input wire logic ref_clk,
  input wire logic rst_n,
  input wire logic [3:0] reg_addr,
  input wire logic [15:0] reg_wdata,
  input wire logic reg_wr,
  input wire logic reg_rd,
  input wire logic [15:0] reg_rdata,
  input wire logic [15:0] src_event_i,
  input wire logic [3:0] cpu_level_i,
  input wire logic trap_req_i,
  input wire logic [3:0] trap_level_i,
  input wire logic cpu_ack_i,
  input wire logic cpu_return_i,
  input wire logic irq_o,
  input wire logic [3:0] irq_level_o,
  input wire logic [6:0] irq_vector_o
);
  default clocking cb @(posedge ref_clk); endclocking
  default disable iff (!rst_n);
  sequence s_gfx_wr; reg_wr && reg_addr == ipc_pkg::OFF_GRAPHICS; endsequence
  sequence s_gfx_rd; reg_rd && reg_addr == ipc_pkg::OFF_GRAPHICS; endsequence
  sequence s_held; irq_o && !cpu_ack_i && !reg_wr && !trap_req_i; endsequence
  property p_rd_idle; !$past(reg_rd) |-> reg_rdata == 16'h0000; endproperty
  a_rd_idle: assert property (p_rd_idle) else $error("read data outside read slot");
  property p_charge; reg_rd && reg_addr == ipc_pkg::OFF_CHARGE |=> (reg_rdata & 16'hFF8F) == 16'h0000; endproperty
  a_charge: assert property (p_charge) else $error("charge register spare bits set");
  property p_gfx; s_gfx_wr ##1 s_gfx_rd |=> reg_rdata == {13'h0000, $past(reg_wdata[2:0], 2)}; endproperty
  a_gfx: assert property (p_gfx) else $error("graphics level readback wrong");
  property p_above; irq_o && irq_level_o <= ipc_pkg::USER_MAX |-> irq_level_o > cpu_level_i; endproperty
  a_above: assert property (p_above) else $error("user request not above cpu level");
  property p_trap; trap_req_i && trap_level_i > ipc_pkg::USER_MAX |-> irq_o; endproperty
  a_trap: assert property (p_trap) else $error("trap request masked");
  property p_vec; irq_o |-> irq_vector_o <= 7'h76; endproperty
  a_vec: assert property (p_vec) else $error("vector out of range");
  property p_nz; irq_o |-> irq_level_o != 4'h0; endproperty
  a_nz: assert property (p_nz) else $error("request at level zero");
  property p_held; s_held ##1 cpu_level_i == $past(cpu_level_i) |-> irq_o; endproperty
  a_held: assert property (p_held) else $error("request dropped without service");
endmodule // ipc_ctrl_monitor
bind ipc_ctrl ipc_ctrl_monitor ipc_ctrl_monitor_inst (.ref_clk(ref_clk), .rst_n(rst_n), .reg_addr(reg_addr),
  .reg_wdata(reg_wdata), .reg_wr(reg_wr), .reg_rd(reg_rd), .reg_rdata(reg_rdata), .src_event_i(src_event_i),
  .cpu_level_i(cpu_level_i), .trap_req_i(trap_req_i), .trap_level_i(trap_level_i), .cpu_ack_i(cpu_ack_i),
  .cpu_return_i(cpu_return_i), .irq_o(irq_o), .irq_level_o(irq_level_o), .irq_vector_o(irq_vector_o));
`default_nettype wire

/* File: ipc_cpu_model.sv */
// Purpose: cpu core taking requests from ipc_ctrl
// Assumes: same clock as the controller
// Notes: acks only when allowed, raises its level to the taken one
`timescale 1ns/1ps
`default_nettype none
module ipc_cpu_model (
  input wire logic ref_clk,
  input wire logic rst_n,
  input wire logic irq_o,
  input wire logic [3:0] irq_level_o,
  input wire logic take_en,
  input wire logic ret_req,
  input wire logic [3:0] base_level,
  output logic [3:0] cpu_level_i,
  output logic cpu_ack_i,
  output logic cpu_return_i
);
  logic busy_ff, ack_ff, ret_ff;
  logic [3:0] lvl_ff;
  assign cpu_level_i = busy_ff ? lvl_ff : base_level;
  assign cpu_ack_i = ack_ff;
  assign cpu_return_i = ret_ff;
  always_ff @(posedge ref_clk) begin
    if (!rst_n) begin
      busy_ff <= 1'b0;
      ack_ff <= 1'b0;
      ret_ff <= 1'b0;
      lvl_ff <= 4'h0;
    end else begin
      // slow taker: one cycle of thought before the ack
      ack_ff <= take_en && irq_o && !ack_ff && !busy_ff;
      ret_ff <= ret_req && busy_ff;
      if (ack_ff && irq_o) begin
        busy_ff <= 1'b1;
        lvl_ff <= irq_level_o;
      end else if (ret_ff) begin
        busy_ff <= 1'b0;
      end
    end
  end
endmodule // ipc_cpu_model
`default_nettype wire

/* File: interrupt_priority_control_tb.sv */
// Purpose: self-checking bench for ipc_ctrl
// Assumes: 250 MHz ref_clk, sync reset
// Notes: scenarios run in order and share register state
`timescale 1ns/1ps
`default_nettype none
module interrupt_priority_control_tb;
  logic ref_clk = 1'b0, rst_n = 1'b0, reg_wr = 1'b0, reg_rd = 1'b0, trap_req_i = 1'b0;
  logic take_en = 1'b0, ret_req = 1'b0, cpu_ack_i, cpu_return_i, irq_o;
  logic [3:0] reg_addr = 4'h0, trap_level_i = 4'h0, base_level = 4'h0, cpu_level_i, irq_level_o;
  logic [15:0] reg_wdata = 16'h0000, src_event_i = 16'h0000, reg_rdata, d;
  logic [6:0] irq_vector_o;
  int n_errors = 0, comparisons = 0;
  localparam logic [15:0] V9 = 16'(ipc_pkg::VEC_BASE) + 16'h0001;
  localparam logic [15:0] RST [6] = '{16'h0040, 16'h4440, 16'h4444, 16'h4444, 16'h0044, 16'h0004};
  localparam logic [15:0] MSK [6] = '{16'h0070, 16'h7770, 16'h7777, 16'h7777, 16'h0077, 16'h0007};
  ipc_ctrl ipc_ctrl_inst (.ref_clk(ref_clk), .rst_n(rst_n), .reg_addr(reg_addr), .reg_wdata(reg_wdata),
    .reg_wr(reg_wr), .reg_rd(reg_rd), .reg_rdata(reg_rdata), .src_event_i(src_event_i),
    .cpu_level_i(cpu_level_i), .trap_req_i(trap_req_i), .trap_level_i(trap_level_i), .cpu_ack_i(cpu_ack_i),
    .cpu_return_i(cpu_return_i), .irq_o(irq_o), .irq_level_o(irq_level_o), .irq_vector_o(irq_vector_o));
  ipc_cpu_model ipc_cpu_model_inst (.ref_clk(ref_clk), .rst_n(rst_n), .irq_o(irq_o), .irq_level_o(irq_level_o),
    .take_en(take_en), .ret_req(ret_req), .base_level(base_level), .cpu_level_i(cpu_level_i),
    .cpu_ack_i(cpu_ack_i), .cpu_return_i(cpu_return_i));
  initial begin
    forever #2 ref_clk = ~ref_clk;
  end
  task automatic chk(input logic [15:0] seen, input logic [15:0] exp);
    comparisons++;
    if (seen !== exp) begin
      n_errors++;
      $display("[FAIL] %0t: got %h want %h", $time, seen, exp);
    end
  endtask
  // strobe left high so writes can run back to back
  task automatic wr(input logic [3:0] a, input logic [15:0] v);
    reg_addr <= a;
    reg_wdata <= v;
    reg_rd <= 1'b0;
    reg_wr <= 1'b1;
    @(posedge ref_clk);
  endtask
  task automatic rd(input logic [3:0] a, output logic [15:0] v);
    reg_addr <= a;
    reg_wr <= 1'b0;
    reg_rd <= 1'b1;
    @(posedge ref_clk);
    reg_rd <= 1'b0;
    @(negedge ref_clk);
    v = reg_rdata;
    @(posedge ref_clk);
  endtask
  task automatic pulse(input logic [15:0] s);
    src_event_i <= s;
    @(posedge ref_clk);
    src_event_i <= 16'h0000;
    @(negedge ref_clk);
  endtask
  task automatic t_regs();
    for (int i = 0; i < 6; i++) begin
      rd(4'(i), d);
      chk(d, RST[i]);
      wr(4'(i), 16'hFFFF);
      rd(4'(i), d);
      chk(d, MSK[i]);
    end
    wr(4'hF, 16'hFFFF);
    rd(4'hF, d);
    chk(d, 16'h0000);
    $display("t_regs done");
  endtask
  task automatic t_irq();
    wr(ipc_pkg::OFF_PENDING, 16'h0000);
    wr(ipc_pkg::OFF_ENABLE, 16'h0006);
    reg_wr <= 1'b0;
    pulse(16'h000E);
    chk({12'h000, irq_level_o}, 16'h0007);
    chk(16'(irq_vector_o), V9);
    @(posedge ref_clk);
    wr(ipc_pkg::OFF_ENABLE, 16'h0000);
    reg_wr <= 1'b0;
    @(negedge ref_clk);
    chk(16'(irq_o), 16'h0000);
    @(posedge ref_clk);
    wr(ipc_pkg::OFF_ENABLE, 16'h0006);
    reg_wr <= 1'b0;
    base_level <= 4'h7;
    @(negedge ref_clk);
    chk(16'(irq_o), 16'h0000);
    @(posedge ref_clk);
    trap_req_i <= 1'b1;
    trap_level_i <= 4'h9;
    @(negedge ref_clk);
    chk(16'(irq_o), 16'h0001);
    @(posedge ref_clk);
    trap_req_i <= 1'b0;
    wr(ipc_pkg::OFF_TEST_STATUS, 16'h2000);
    rd(ipc_pkg::OFF_TEST_STATUS, d);
    chk(d & 16'hA07F, 16'hA000 | V9);
    base_level <= 4'h0;
    take_en <= 1'b1;
    for (int k = 0; k < 20 && cpu_ack_i !== 1'b1; k++) @(negedge ref_clk);
    @(posedge ref_clk);
    take_en <= 1'b0;
    @(negedge ref_clk);
    chk(16'(irq_o), 16'h0000);
    @(posedge ref_clk);
    wr(ipc_pkg::OFF_TEST_STATUS, 16'h0000);
    rd(ipc_pkg::OFF_TEST_STATUS, d);
    chk(d & 16'h2F7F, 16'h0700 | V9);
    ret_req <= 1'b1;
    @(posedge ref_clk);
    ret_req <= 1'b0;
    repeat (3) @(posedge ref_clk);
    @(negedge ref_clk);
    chk(16'(irq_o), 16'h0001);
    @(posedge ref_clk);
    wr(ipc_pkg::OFF_PENDING, 16'h0000);
    wr(ipc_pkg::OFF_UART3, 16'h7070);
    reg_wr <= 1'b0;
    pulse(16'h0004);
    chk(16'(irq_o), 16'h0000);
    @(posedge ref_clk);
    rd(ipc_pkg::OFF_TEST_STATUS, d);
    chk(d & 16'h8000, 16'h0000);
    $display("t_irq done");
  endtask
  // nesting disable holds off a higher level while one is in service
  task automatic t_nest();
    @(posedge ref_clk);
    wr(ipc_pkg::OFF_CONTROL_ONE, 16'hFFFF);
    rd(ipc_pkg::OFF_CONTROL_ONE, d);
    chk(d, 16'h8000);
    wr(ipc_pkg::OFF_UART3, 16'h7010);
    wr(ipc_pkg::OFF_PENDING, 16'h0000);
    wr(ipc_pkg::OFF_ENABLE, 16'h000A);
    reg_wr <= 1'b0;
    pulse(16'h0002);
    chk({12'h000, irq_level_o}, 16'h0001);
    @(posedge ref_clk);
    take_en <= 1'b1;
    for (int k = 0; k < 20 && cpu_ack_i !== 1'b1; k++) @(negedge ref_clk);
    @(posedge ref_clk);
    take_en <= 1'b0;
    pulse(16'h0008);
    chk(16'(irq_o), 16'h0000);
    @(posedge ref_clk);
    rd(ipc_pkg::OFF_TEST_STATUS, d);
    chk(d & 16'hAF00, 16'h8100);
    rd(ipc_pkg::OFF_CPU_LEVEL, d);
    chk(d, 16'h0001);
    ret_req <= 1'b1;
    @(posedge ref_clk);
    ret_req <= 1'b0;
    repeat (2) @(posedge ref_clk);
    @(negedge ref_clk);
    chk(16'(irq_o), 16'h0001);
    chk(16'(irq_vector_o), 16'(ipc_pkg::VEC_BASE) + 16'(ipc_pkg::S_U3TX));
    @(posedge ref_clk);
    wr(ipc_pkg::OFF_CONTROL_ONE, 16'h0000);
    src_event_i <= 16'h0001;
    wr(ipc_pkg::OFF_PENDING, 16'h0000);
    src_event_i <= 16'h0000;
    rd(ipc_pkg::OFF_PENDING, d);
    chk(d, 16'h0001);
    rd(ipc_pkg::OFF_ENABLE, d);
    chk(d, 16'h000A);
    wr(ipc_pkg::OFF_PENDING, 16'h0000);
    reg_wr <= 1'b0;
    $display("t_nest done");
  endtask
  task automatic print_verdict();
    $display("comparisons %0d errors %0d", comparisons, n_errors);
    if (n_errors == 0 && comparisons > 0) $display("No errors found");
    else $display("Errors were found");
    $finish;
  endtask
  initial begin
    repeat (3) @(posedge ref_clk);
    rst_n <= 1'b1;
    @(posedge ref_clk);
    t_regs();
    t_irq();
    t_nest();
    print_verdict();
  end
  initial begin
    repeat (2000) @(posedge ref_clk);
    n_errors++;
    print_verdict();
  end
endmodule // interrupt_priority_control_tb
`default_nettype wire
